// ==== logic/pcsi_core.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pcsi_params.svh"
module pcsi_core
  import pcsi_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire pcsi_flow_s flow,
  input  wire pcsi_data_s data,
  input  wire logic [7:0] data_rdata,
  input  wire logic [7:0] status_byte,
  output logic [12:0]     fetch_addr,
  output pcsi_mem_s       mem,
  output logic [7:0]      read_data,
  output logic            read_valid
);
  typedef struct packed {
    logic [12:0] program_counter;
    logic [4:0]  pc_high_latch;
    logic [7:0]  indirect_pointer;
    pcsi_mem_s   mem;
    logic [7:0]  read_data;
    logic        read_valid;
    logic        pend_rd;
    logic        pend_zero;
  } pcsi_core_s;

  pcsi_core_s st;
  pcsi_core_s next_st;
  logic       push;
  logic       pop;
  logic [12:0] stack_top;
  pcsi_mem_s  mem_req;
  logic       rd_zero;
  logic       wr_low;
  logic [7:0] local_rd;
  logic       local_hit;

  pcsi_stack #(
    .DEPTH (`PCSI_STACK_DEPTH),
    .WIDTH (`PCSI_PC_W)
  ) u_stack (
    .mclk      (mclk),
    .resetn    (resetn),
    .push      (push),
    .pop       (pop),
    .push_data (st.program_counter),
    .top       (stack_top)
  );

  pcsi_indirect u_ind (
    .bank_bit  (status_byte[`PCSI_BANK_BIT]),
    .pointer   (st.indirect_pointer),
    .req       (data),
    .mem       (mem_req),
    .read_zero (rd_zero)
  );

  // Stack control from the flow request
  always_comb begin
    push = flow.step && (flow.act == PCSI_ACT_CALL || flow.act == PCSI_ACT_INTR);
    pop  = flow.step && (flow.act == PCSI_ACT_RETURN);
  end

  // Registers held locally: low byte, latch, pointer
  always_comb begin
    wr_low    = data.wr && data.addr == `PCSI_LOW_ADDR;
    local_hit = 1'b1;
    local_rd  = 8'h00;
    if (data.addr == `PCSI_LOW_ADDR) begin
      local_rd = st.program_counter[7:0];
    end else if (data.addr == `PCSI_LATCH_ADDR) begin
      local_rd = {3'h0, st.pc_high_latch};
    end else if (data.addr == `PCSI_PTR_ADDR) begin
      local_rd = st.indirect_pointer;
    end else begin
      local_hit = 1'b0;
    end
  end

  // Next state of counter, latch, pointer and data path
  always_comb begin
    next_st = st;
    // Latch only changes by explicit write, never by stack use
    if (data.wr && data.addr == `PCSI_LATCH_ADDR) begin
      next_st.pc_high_latch = data.wdata[4:0];
    end
    if (data.wr && data.addr == `PCSI_PTR_ADDR) begin
      next_st.indirect_pointer = data.wdata;
    end
    if (wr_low) begin
      next_st.program_counter = {st.pc_high_latch, data.wdata};
    end else if (flow.step) begin
      case (flow.act)
        PCSI_ACT_JUMP, PCSI_ACT_CALL: begin
          next_st.program_counter = {st.pc_high_latch[`PCSI_PAGE_HI:`PCSI_PAGE_LO],
                                     flow.target};
        end
        PCSI_ACT_RETURN: begin
          next_st.program_counter = stack_top;
        end
        PCSI_ACT_INTR: begin
          next_st.program_counter = flow.vector;
        end
        PCSI_ACT_HOLD: begin
          next_st.program_counter = st.program_counter;
        end
        default: begin
          next_st.program_counter = 13'(st.program_counter + 1'b1);
        end
      endcase
    end
    // Local registers are not forwarded to data memory
    next_st.mem = mem_req;
    if (local_hit) begin
      next_st.mem.rd = 1'b0;
      next_st.mem.wr = 1'b0;
    end
    next_st.read_valid = 1'b0;
    next_st.read_data  = 8'h00;
    if (st.pend_rd) begin
      next_st.read_valid = 1'b1;
      next_st.read_data  = st.pend_zero ? 8'h00 : data_rdata;
    end
    next_st.pend_rd   = mem_req.rd && !local_hit || rd_zero;
    next_st.pend_zero = rd_zero;
    if (data.rd && local_hit) begin
      next_st.read_valid = 1'b1;
      next_st.read_data  = local_rd;
      next_st.pend_rd    = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st.program_counter  <= `PCSI_PC_RESET;
      st.pc_high_latch    <= `PCSI_LATCH_RESET;
      st.indirect_pointer <= `PCSI_PTR_RESET;
      st.mem              <= '0;
      st.read_data        <= 8'h00;
      st.read_valid       <= 1'b0;
      st.pend_rd          <= 1'b0;
      st.pend_zero        <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign fetch_addr = st.program_counter;
  assign mem        = st.mem;
  assign read_data  = st.read_data;
  assign read_valid = st.read_valid;
endmodule : pcsi_core
`default_nettype wire

// ==== logic/pcsi_params.svh ====
// What this block does
// - Keep a 13-bit program counter addressing the next instruction fetch.
// - Low counter byte is readable and writable as a register.
// - Counter bits 12..8 are loaded from the high latch on a low-byte write.
// - Address a contiguous 8K-word program space.
// - Call and jump take 11 bits plus latch bits 4..3 on top.
// - Returns reload the full counter from the stack top, no latch bits.
// - Stack holds 8 entries of 13 bits; its pointer is hidden.
// - Push the counter on call or on an interrupt branch.
// - Pop on return, return with literal, return from interrupt.
// - Pushes and pops leave the high latch unchanged.
// - Stack wraps circularly; ninth push overwrites the first, no overflow flag.
// - Indirect window access goes to the data-memory register the pointer addresses, never to a locally held one.
// - Reading the window with pointer zero returns zero.
// - Writing the window through itself stores nothing.
// - Indirect address is bank bit over the 8-bit pointer, 9 bits.
`ifndef PCSI_PARAMS_SVH
`define PCSI_PARAMS_SVH
`define PCSI_PC_W        13
`define PCSI_STACK_DEPTH 8
`define PCSI_LATCH_W     5
`define PCSI_TARGET_W    11
`define PCSI_PAGE_HI     4
`define PCSI_PAGE_LO     3
`define PCSI_ADDR_W      9
`define PCSI_WINDOW_ADDR 8'h00
`define PCSI_LOW_ADDR    8'h02
`define PCSI_PTR_ADDR    8'h04
`define PCSI_LATCH_ADDR  8'h0a
`define PCSI_STATUS_ADDR 8'h03
`define PCSI_BANK_BIT    7
`define PCSI_PC_RESET    13'h0000
`define PCSI_LATCH_RESET 5'h00
`define PCSI_PTR_RESET   8'h00
`endif

// ==== logic/pcsi_pkg.sv ====
package pcsi_pkg;
  // Program-flow action requested by the decoder for one fetch
  typedef enum logic [5:0] {
    PCSI_ACT_NONE   = 6'b000001,
    PCSI_ACT_JUMP   = 6'b000010,
    PCSI_ACT_CALL   = 6'b000100,
    PCSI_ACT_RETURN = 6'b001000,
    PCSI_ACT_INTR   = 6'b010000,
    PCSI_ACT_HOLD   = 6'b100000
  } pcsi_act_e;

  // One flow request from the decoder
  typedef struct packed {
    logic        step;
    pcsi_act_e   act;
    logic [10:0] target;
    logic [12:0] vector;
  } pcsi_flow_s;

  // One data-space access from the decoder
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcsi_data_s;

  // Resolved data-space access toward data memory
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [8:0] addr;
    logic [7:0] wdata;
  } pcsi_mem_s;
endpackage : pcsi_pkg

// ==== logic/pcsi_stack.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pcsi_params.svh"
module pcsi_stack
  import pcsi_pkg::*;
#(
  parameter int DEPTH = `PCSI_STACK_DEPTH,
  parameter int WIDTH = `PCSI_PC_W
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0]             ptr;
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } pcsi_stk_s;

  pcsi_stk_s st;
  pcsi_stk_s next_st;

  // Top entry is the one below the write pointer
  assign top = st.mem[PW'(st.ptr - 1'b1)];

  // Circular pointer, no overflow or underflow indication
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.ptr] = push_data;
      next_st.ptr         = PW'(st.ptr + 1'b1);
    end else if (pop) begin
      next_st.ptr = PW'(st.ptr - 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : pcsi_stack
`default_nettype wire

// ==== logic/pcsi_indirect.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "pcsi_params.svh"
module pcsi_indirect
  import pcsi_pkg::*;
(
  input  wire logic       bank_bit,
  input  wire logic [7:0] pointer,
  input  wire pcsi_data_s req,
  output pcsi_mem_s       mem,
  output logic            read_zero
);
  logic is_window;
  logic self_ref;

  // Redirect window accesses through the pointer
  always_comb begin
    is_window = (req.addr == `PCSI_WINDOW_ADDR);
    self_ref  = is_window && (pointer == `PCSI_WINDOW_ADDR);
    mem.wdata = req.wdata;
    if (is_window) begin
      mem.addr = {bank_bit, pointer};
    end else begin
      mem.addr = {1'b0, req.addr};
    end
    mem.rd    = req.rd && !self_ref;
    mem.wr    = req.wr && !self_ref;
    read_zero = req.rd && self_ref;
  end
endmodule : pcsi_indirect
`default_nettype wire

// ==== tb/pcsi_dmem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcsi_dmem_model
  import pcsi_pkg::*;
(
  input  wire logic       mclk,
  input  wire pcsi_mem_s  mem,
  output logic      [7:0] data_rdata
);
  logic [7:0] ram [512];
  // Preload a pattern that differs per address within each 256-entry half
  initial begin
    for (int i = 0; i < 512; i++) ram[i] = i[7:0] ^ 8'ha5;
  end
  // Store one byte per write strobe
  always @(posedge mclk) begin
    if (mem.wr) ram[mem.addr] <= mem.wdata;
  end
  // Outside a read the bus carries inverted data, never a stale match
  assign data_rdata = mem.rd ? ram[mem.addr] : ~ram[mem.addr];
endmodule : pcsi_dmem_model
`default_nettype wire

// ==== tb/pcsi_core_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module pcsi_core_asserts
  import pcsi_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire pcsi_flow_s  flow,
  input wire pcsi_data_s  data,
  input wire logic [7:0]  data_rdata,
  input wire logic [7:0]  status_byte,
  input wire logic [12:0] fetch_addr,
  input wire pcsi_mem_s   mem,
  input wire logic [7:0]  read_data,
  input wire logic        read_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Flow properties
  property p_hold;
    !flow.step && !(data.wr && data.addr == 8'h02) |=> $stable(fetch_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved while idle");
  property p_inc;
    flow.step && flow.act == PCSI_ACT_NONE && !data.wr |=> fetch_addr == $past(fetch_addr) + 13'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not step by one");
  property p_branch;
    flow.step && flow.act inside {PCSI_ACT_JUMP, PCSI_ACT_CALL} && !data.wr
      |=> fetch_addr[10:0] == $past(flow.target);
  endproperty
  a_branch: assert property (p_branch) else $error("branch target lost");
  property p_intr;
    flow.step && flow.act == PCSI_ACT_INTR && !data.wr |=> fetch_addr == $past(flow.vector);
  endproperty
  a_intr: assert property (p_intr) else $error("vector not taken");
  // Data path properties
  property p_low_rd;
    data.rd && data.addr == 8'h02 && !flow.step |=> read_valid && read_data == fetch_addr[7:0];
  endproperty
  a_low_rd: assert property (p_low_rd) else $error("low byte read wrong");
  property p_mem_rd;
    mem.rd |=> read_valid && read_data == $past(data_rdata);
  endproperty
  a_mem_rd: assert property (p_mem_rd) else $error("memory read not returned");
  property p_local_wr;
    data.wr && data.addr inside {8'h02, 8'h04, 8'h0a} |=> !mem.wr;
  endproperty
  a_local_wr: assert property (p_local_wr) else $error("local write leaked");
  property p_bank;
    data.addr == 8'h00 && (data.rd || data.wr) |=> !(mem.rd || mem.wr) || mem.addr[8] == $past(status_byte[7]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank bit wrong");
  property p_win_zero;
    data.rd && data.addr == 8'h00 ##1 !mem.rd |=> read_valid && read_data == 8'h00;
  endproperty
  a_win_zero: assert property (p_win_zero) else $error("null window read not zero");
  c_call: cover property (flow.step && flow.act == PCSI_ACT_CALL);
  c_ret: cover property (flow.step && flow.act == PCSI_ACT_RETURN);
  c_win: cover property (mem.wr ##1 mem.rd);
endmodule : pcsi_core_asserts
bind pcsi_core pcsi_core_asserts chk_u (.mclk(mclk), .resetn(resetn), .flow(flow), .data(data),
  .data_rdata(data_rdata), .status_byte(status_byte), .fetch_addr(fetch_addr), .mem(mem),
  .read_data(read_data), .read_valid(read_valid));
`default_nettype wire

// ==== tb/pcsi_core_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module program_counter_stack_indirect_tb_top;
  import pcsi_pkg::*;
  logic        mclk = 0;
  logic        resetn = 0;
  logic        read_valid;
  logic [7:0]  status_byte, data_rdata, read_data, v;
  logic [12:0] fetch_addr;
  logic [12:0] p [9];
  pcsi_flow_s  flow;
  pcsi_data_s  data;
  pcsi_mem_s   mem;
  int          n_errors = 0;
  int          check_count = 0;
  // Clock
  initial forever #25 mclk = ~mclk;
  pcsi_core dut_u (.mclk(mclk), .resetn(resetn), .flow(flow), .data(data),
    .data_rdata(data_rdata), .status_byte(status_byte), .fetch_addr(fetch_addr), .mem(mem),
    .read_data(read_data), .read_valid(read_valid));
  pcsi_dmem_model mem_u (.mclk(mclk), .mem(mem), .data_rdata(data_rdata));
  // Shared helpers
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic cyc();
    @(posedge mclk);
    #1;
  endtask : cyc
  task automatic chk(string n, logic [12:0] e, logic [12:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic fl(pcsi_act_e a, logic [10:0] t);
    flow = '{1'b1, a, t, 13'h1abc};
    cyc();
    flow.step = 1'b0;
    cyc(); // Idle edge keeps back-to-back strobes apart
  endtask : fl
  task automatic wr(logic [7:0] a, logic [7:0] d);
    data = '{1'b0, 1'b1, a, d};
    cyc();
    data.wr = 1'b0;
    cyc(); // Idle edge keeps back-to-back strobes apart
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [7:0] r);
    data = '{1'b1, 1'b0, a, 8'h00};
    cyc();
    data.rd = 1'b0;
    // Look before each further edge: read_valid stands one cycle only
    for (int i = 0; i < 4; i++) begin
      if (read_valid === 1'b1) begin
        r = read_data;
        cyc();
        return;
      end
      cyc();
    end
    $display("[ERR] read_valid expected 1 seen 0");
    n_errors++;
    summarize();
  endtask : rd
  // Counter, paging and low byte
  task automatic s_flow();
    chk("reset pc", 13'h0, fetch_addr);
    repeat (3) fl(PCSI_ACT_NONE, 11'h0);
    chk("inc", 13'h3, fetch_addr);
    wr(8'h0a, 8'h17);
    fl(PCSI_ACT_JUMP, 11'h123);
    chk("jump", 13'h1123, fetch_addr);
    fl(PCSI_ACT_HOLD, 11'h0);
    chk("hold", 13'h1123, fetch_addr);
    wr(8'h02, 8'h44);
    chk("low wr", 13'h1744, fetch_addr);
    rd(8'h02, v);
    chk("low rd", 13'h44, v);
  endtask : s_flow
  // Nine pushes wrap, returns ignore the page bits
  task automatic s_stack();
    wr(8'h0a, 8'h08);
    wr(8'h02, 8'h10);
    p[0] = 13'h0810;
    for (int i = 0; i < 8; i++) begin
      fl(PCSI_ACT_CALL, 11'h100 + 11'(i));
      p[i+1] = 13'h0900 + 13'(i);
    end
    fl(PCSI_ACT_INTR, 11'h0);
    chk("intr", 13'h1abc, fetch_addr);
    wr(8'h0a, 8'h18);
    for (int k = 8; k > 0; k--) begin
      fl(PCSI_ACT_RETURN, 11'h0);
      chk("pop", p[k], fetch_addr);
    end
    fl(PCSI_ACT_RETURN, 11'h0);
    chk("wrap", p[8], fetch_addr);
    rd(8'h0a, v);
    chk("latch", 13'h18, v);
  endtask : s_stack
  // Indirect window through both banks and the null pointer
  task automatic s_ind();
    status_byte = 8'h80;
    wr(8'h04, 8'h30);
    wr(8'h00, 8'h5a);
    rd(8'h00, v);
    chk("win hi", 13'h5a, v);
    status_byte = 8'h00;
    rd(8'h00, v);
    chk("win lo", 13'h95, v);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h77);
    rd(8'h00, v);
    chk("win null", 13'h0, v);
    chk("no store", 13'ha5, mem_u.ram[0]);
  endtask : s_ind
  // Main sequence
  initial begin
    flow = '{1'b0, PCSI_ACT_NONE, 11'h0, 13'h0};
    data = '0;
    status_byte = 8'h00;
    repeat (6) @(posedge mclk);
    #1 resetn = 1'b1;
    s_flow();
    s_stack();
    s_ind();
    summarize();
  end
endmodule : program_counter_stack_indirect_tb_top
`default_nettype wire
